/* File: logic/core_interrupt_controller.sv */
/*
  Core interrupt controller: flag and enable registers on APB, external
  pin edge capture, vectoring sequencer with context shadow, wake logic.
  Assumes a core that acts on the CORE_CTL pulses, peripheral events as
  one-cycle pulses on CORE_CLK, and an asynchronous external pin.
*/
`timescale 1ns/10ps
`default_nettype none

// Operation
// (RULE_01) Any reset clears global, peripheral and per-source enables.
// (RULE_02) Redirect needs global and own enable; peripheral sources also peripheral enable.
// (RULE_03) Event sets its flag whatever the enables are.
// (RULE_04) Entry flushes prefetch, clears global enable, pushes PC, saves context, vectors.
// (RULE_05) Global enable clear: only record flags; pending served once re-enabled.
// (RULE_06) Return pops address, restores context, sets global enable.
// (RULE_07) Handler clears serviced flags before returning, else re-entry.
// (RULE_08) Event to vector: three-four cycles synchronous, three-five asynchronous.
// (RULE_09) Latency independent of one- or two-cycle current instruction.
// (RULE_10) External flag sampled each first quarter, may set fourth to first.
// (RULE_11) Wake sources need enables set before sleep and run clockless.
// (RULE_12) On wake vector when global enable set, else continue after sleep.
// (RULE_13) Instruction after sleep always executes before branching to handler.
// (RULE_14) External pin is edge-triggered; select bit chooses rising or falling.
// (RULE_15) Valid edge sets external flag; redirect needs its enable and global.
// (RULE_16) Entry saves work, status less timeout/powerdown, bank, file select, PC high.
// (RULE_17) Shadows are software accessible; their values restore on exit.
// (RULE_18) Control register: global, peripheral, timer, pin, change enables, then flags.
// (RULE_19) Change flag is read-only, one while any pin-change flag set.
// (RULE_20) First peripheral enable register holds eight peripheral enables.
// (RULE_21) Timer-zero flag set on overflow, held until software clears it.
// (RULE_22) Software should clear a flag before setting its enable.
// (RULE_23) Request is global AND (core terms OR peripheral enable AND peripheral terms).
module core_interrupt_controller (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_ZERO_OVF,
  input wire logic [7:0] PERIPH_EVT_ONE,
  input wire logic [7:0] PERIPH_EVT_TWO,
  input wire logic PIN_CHANGE_ANY,
  input wire logic EXT_PIN,
  input wire logic SLEEP_ACTIVE,
  input wire logic RETURN_INSTR,
  input wire irq_pkg::ctx_t CTX_IN,
  output var irq_pkg::ctl_t CORE_CTL,
  output var irq_pkg::ctx_t CTX_OUT,
  output logic [irq_pkg::PC_W-1:0] PC_VECTOR
);
  typedef struct packed {
    logic [7:0] int_control;
    logic [7:0] periph_en_one;
    logic [7:0] periph_en_two;
    logic [7:0] periph_flag_one;
    logic [7:0] periph_flag_two;
    logic [7:0] option;
    irq_pkg::ctx_t shadow;
    irq_pkg::seq_t seq;
    logic [1:0] pin_sync;
    logic pin_last;
    irq_pkg::ctl_t ctl;
    irq_pkg::ctx_t ctx_out;
    logic [irq_pkg::PC_W-1:0] pc_vec;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  logic q1;
  logic global_irq_enable;
  logic periph_irq_enable;
  logic ext_edge;
  logic core_w;
  logic per_w;
  logic req_w;
  logic wake_w;
  logic setup_w;
  logic wr_w;
  logic [31:0] rd_w;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == irq_pkg::ADDR_INT_CONTROL) || (a == irq_pkg::ADDR_PERIPH_EN_ONE) ||
               (a == irq_pkg::ADDR_PERIPH_EN_TWO) || (a == irq_pkg::ADDR_PERIPH_FLAG_ONE) ||
               (a == irq_pkg::ADDR_PERIPH_FLAG_TWO) || (a == irq_pkg::ADDR_OPTION) ||
               (a == irq_pkg::ADDR_SHADOW_LO) || (a == irq_pkg::ADDR_SHADOW_HI) ||
               (a == irq_pkg::ADDR_SEQ_STATUS);
  endfunction

  qphase_gen u_qphase (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .q1_en(q1)
  );

  assign global_irq_enable = state_ff.int_control[irq_pkg::BIT_GLOBAL_EN];
  assign periph_irq_enable = state_ff.int_control[irq_pkg::BIT_PERIPH_EN];
  // edge seen on the second synchroniser stage against its delayed copy
  assign ext_edge = state_ff.option[irq_pkg::BIT_EDGE_SEL] ?
                    (state_ff.pin_sync[1] & ~state_ff.pin_last) :
                    (~state_ff.pin_sync[1] & state_ff.pin_last); // RULE_14
  assign core_w = (state_ff.int_control[irq_pkg::BIT_T0_EN] &
                   state_ff.int_control[irq_pkg::BIT_T0_FLAG]) |
                  (state_ff.int_control[irq_pkg::BIT_EXT_EN] &
                   state_ff.int_control[irq_pkg::BIT_EXT_FLAG]) | // RULE_15
                  (state_ff.int_control[irq_pkg::BIT_CHG_EN] & PIN_CHANGE_ANY);
  assign per_w = periph_irq_enable & (|((state_ff.periph_en_one & state_ff.periph_flag_one) |
                           (state_ff.periph_en_two & state_ff.periph_flag_two))); // RULE_02
  assign req_w = global_irq_enable & (core_w | per_w); // RULE_23
  // wake ignores the global enable; enables must already be set
  assign wake_w = core_w | per_w; // RULE_11
  assign setup_w = PSEL & PENABLE & ~state_ff.pready;
  assign wr_w = PSEL & PENABLE & state_ff.pready & PWRITE;

  always_comb begin
    rd_w = 32'h0000_0000;
    if (PADDR == irq_pkg::ADDR_INT_CONTROL) begin
      rd_w[7:0] = {state_ff.int_control[7:1], PIN_CHANGE_ANY}; // RULE_18 RULE_19
    end else if (PADDR == irq_pkg::ADDR_PERIPH_EN_ONE) begin
      rd_w[7:0] = state_ff.periph_en_one;
    end else if (PADDR == irq_pkg::ADDR_PERIPH_EN_TWO) begin
      rd_w[7:0] = state_ff.periph_en_two;
    end else if (PADDR == irq_pkg::ADDR_PERIPH_FLAG_ONE) begin
      rd_w[7:0] = state_ff.periph_flag_one;
    end else if (PADDR == irq_pkg::ADDR_PERIPH_FLAG_TWO) begin
      rd_w[7:0] = state_ff.periph_flag_two;
    end else if (PADDR == irq_pkg::ADDR_OPTION) begin
      rd_w[7:0] = state_ff.option;
    end else if (PADDR == irq_pkg::ADDR_SHADOW_LO) begin
      rd_w = state_ff.shadow[31:0]; // RULE_17
    end else if (PADDR == irq_pkg::ADDR_SHADOW_HI) begin
      rd_w = state_ff.shadow[63:32];
    end else if (PADDR == irq_pkg::ADDR_SEQ_STATUS) begin
      rd_w = {22'h00_0000, wake_w, req_w, 5'h00, state_ff.seq};
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.ctl = '0;
    nxt_state.pready = 1'b0;
    nxt_state.pslverr = 1'b0;
    nxt_state.pin_sync = {state_ff.pin_sync[0], EXT_PIN};
    nxt_state.pin_last = state_ff.pin_sync[1];
    // one wait state: answer registered in the first access cycle
    if (setup_w) begin
      nxt_state.pready = 1'b1;
      nxt_state.pslverr = !addr_hit(PADDR);
      nxt_state.prdata = addr_hit(PADDR) ? rd_w : 32'h0000_0000;
    end
    if (wr_w) begin
      if (PADDR == irq_pkg::ADDR_INT_CONTROL) begin
        nxt_state.int_control = {PWDATA[7:1], 1'b0}; // RULE_19
      end else if (PADDR == irq_pkg::ADDR_PERIPH_EN_ONE) begin
        nxt_state.periph_en_one = PWDATA[7:0]; // RULE_20
      end else if (PADDR == irq_pkg::ADDR_PERIPH_EN_TWO) begin
        nxt_state.periph_en_two = PWDATA[7:0] & irq_pkg::PERIPH_TWO_MASK;
      end else if (PADDR == irq_pkg::ADDR_PERIPH_FLAG_ONE) begin
        nxt_state.periph_flag_one = PWDATA[7:0];
      end else if (PADDR == irq_pkg::ADDR_PERIPH_FLAG_TWO) begin
        nxt_state.periph_flag_two = PWDATA[7:0] & irq_pkg::PERIPH_TWO_MASK;
      end else if (PADDR == irq_pkg::ADDR_OPTION) begin
        nxt_state.option = PWDATA[7:0];
      end else if (PADDR == irq_pkg::ADDR_SHADOW_LO) begin
        nxt_state.shadow[31:0] = PWDATA; // RULE_17
      end else if (PADDR == irq_pkg::ADDR_SHADOW_HI) begin
        nxt_state.shadow[63:32] = PWDATA;
      end
    end
    // events set flags after the software write, so a set wins a clear
    nxt_state.int_control[irq_pkg::BIT_T0_FLAG] =
      nxt_state.int_control[irq_pkg::BIT_T0_FLAG] | TIMER_ZERO_OVF; // RULE_03 RULE_21
    nxt_state.int_control[irq_pkg::BIT_EXT_FLAG] =
      nxt_state.int_control[irq_pkg::BIT_EXT_FLAG] | ext_edge; // RULE_15
    nxt_state.periph_flag_one = nxt_state.periph_flag_one | PERIPH_EVT_ONE; // RULE_03
    nxt_state.periph_flag_two = nxt_state.periph_flag_two |
                                (PERIPH_EVT_TWO & irq_pkg::PERIPH_TWO_MASK);
    case (state_ff.seq)
      irq_pkg::S_IDLE: begin
        if (SLEEP_ACTIVE) begin
          if (wake_w) begin
            nxt_state.ctl.wake = 1'b1; // RULE_12
            nxt_state.seq = irq_pkg::S_WAKE;
          end
        end else if (q1 && req_w) begin
          // taken at any quarter-one, no wait for an instruction boundary
          nxt_state.ctl.flush = 1'b1; // RULE_04 RULE_05 RULE_09 RULE_10
          nxt_state.int_control[irq_pkg::BIT_GLOBAL_EN] = 1'b0; // RULE_04
          nxt_state.seq = irq_pkg::S_FLUSH;
        end else if (RETURN_INSTR) begin
          nxt_state.ctl.stack_pop = 1'b1; // RULE_06
          nxt_state.ctl.ctx_restore = 1'b1;
          nxt_state.ctx_out = state_ff.shadow; // RULE_16 RULE_17
          nxt_state.ctx_out.status = (state_ff.shadow.status & ~irq_pkg::STATUS_KEEP_MASK) |
                                     (CTX_IN.status & irq_pkg::STATUS_KEEP_MASK);
          nxt_state.int_control[irq_pkg::BIT_GLOBAL_EN] = 1'b1; // RULE_06
        end
      end
      irq_pkg::S_FLUSH: begin
        if (q1) begin
          nxt_state.ctl.stack_push = 1'b1; // RULE_04
          nxt_state.shadow = CTX_IN; // RULE_16
          nxt_state.shadow.status = CTX_IN.status & ~irq_pkg::STATUS_KEEP_MASK;
          nxt_state.seq = irq_pkg::S_PUSH;
        end
      end
      irq_pkg::S_PUSH: begin
        if (q1) begin
          nxt_state.ctl.pc_load = 1'b1; // RULE_04 RULE_08
          nxt_state.pc_vec = irq_pkg::VECTOR_ADDR;
          nxt_state.seq = irq_pkg::S_IDLE;
        end
      end
      irq_pkg::S_WAKE: begin
        // the instruction after sleep runs in this cycle before any entry
        if (q1) begin
          nxt_state.seq = irq_pkg::S_IDLE; // RULE_13
        end
      end
      default: nxt_state.seq = irq_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= '0;
      state_ff.int_control <= irq_pkg::INT_CONTROL_RST; // RULE_01
      state_ff.periph_en_one <= irq_pkg::PERIPH_EN_RST;
      state_ff.periph_en_two <= irq_pkg::PERIPH_EN_RST;
      state_ff.periph_flag_one <= irq_pkg::PERIPH_FLAG_RST;
      state_ff.periph_flag_two <= irq_pkg::PERIPH_FLAG_RST;
      state_ff.option <= irq_pkg::OPTION_RST;
      state_ff.seq <= irq_pkg::S_IDLE;
      state_ff.pc_vec <= irq_pkg::VECTOR_ADDR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign PRDATA = state_ff.prdata;
  assign PREADY = state_ff.pready;
  assign PSLVERR = state_ff.pslverr;
  assign CORE_CTL = state_ff.ctl;
  assign CTX_OUT = state_ff.ctx_out;
  assign PC_VECTOR = state_ff.pc_vec;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  logic wr_int_ctl;
  assign wr_int_ctl = wr_w && (PADDR == irq_pkg::ADDR_INT_CONTROL);

  property p_reset_off;
    $rose(RSTN) |-> (state_ff.int_control[7:3] == 5'h00) &&
                    (state_ff.periph_en_one == 8'h00) && (state_ff.periph_en_two == 8'h00);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enables not clear after reset"); // RULE_01

  property p_gate;
    $rose(state_ff.ctl.flush) |-> $past(req_w) && $past(q1);
  endproperty
  a_gate: assert property (p_gate) else $error("entry without enabled request"); // RULE_02

  property p_flag_set;
    TIMER_ZERO_OVF |=> state_ff.int_control[irq_pkg::BIT_T0_FLAG];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("timer flag not set"); // RULE_03

  property p_entry;
    state_ff.ctl.flush |-> !global_irq_enable ##4 state_ff.ctl.stack_push ##4
      (state_ff.ctl.pc_load && PC_VECTOR == irq_pkg::VECTOR_ADDR);
  endproperty
  a_entry: assert property (p_entry) else $error("entry sequence wrong"); // RULE_04

  property p_hold_off;
    (state_ff.seq == irq_pkg::S_IDLE) && !global_irq_enable |=> !state_ff.ctl.flush;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("entry while disabled"); // RULE_05

  property p_return;
    (state_ff.seq == irq_pkg::S_IDLE) && RETURN_INSTR && !SLEEP_ACTIVE && !(q1 && req_w)
      |=> state_ff.ctl.stack_pop && state_ff.ctl.ctx_restore && global_irq_enable &&
          (CTX_OUT.work == $past(state_ff.shadow.work));
  endproperty
  a_return: assert property (p_return) else $error("return sequence wrong"); // RULE_06

  property p_latency;
    TIMER_ZERO_OVF && global_irq_enable && state_ff.int_control[irq_pkg::BIT_T0_EN] && !req_w &&
      (state_ff.seq == irq_pkg::S_IDLE) && !SLEEP_ACTIVE && !wr_w && !RETURN_INSTR
      |-> ##[10:13] state_ff.ctl.pc_load;
  endproperty
  a_latency: assert property (p_latency) else $error("latency out of range"); // RULE_08

  property p_ext_edge;
    ext_edge |=> state_ff.int_control[irq_pkg::BIT_EXT_FLAG];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("pin edge lost"); // RULE_14

  property p_chg_read;
    setup_w && !PWRITE && (PADDR == irq_pkg::ADDR_INT_CONTROL)
      |=> PREADY && (PRDATA[0] == $past(PIN_CHANGE_ANY));
  endproperty
  a_chg_read: assert property (p_chg_read) else $error("change flag misread"); // RULE_19

  property p_t0_sticky;
    state_ff.int_control[irq_pkg::BIT_T0_FLAG] && !wr_int_ctl
      |=> state_ff.int_control[irq_pkg::BIT_T0_FLAG];
  endproperty
  a_t0_sticky: assert property (p_t0_sticky) else $error("timer flag dropped"); // RULE_21

  property p_wake_first;
    state_ff.ctl.wake |-> !state_ff.ctl.flush [*5];
  endproperty
  a_wake_first: assert property (p_wake_first) else $error("entry before next instr"); // RULE_13

  property p_shadow_save;
    state_ff.ctl.stack_push |-> (state_ff.shadow.work == $past(CTX_IN.work)) &&
      ((state_ff.shadow.status & irq_pkg::STATUS_KEEP_MASK) == 8'h00);
  endproperty
  a_shadow_save: assert property (p_shadow_save) else $error("context not saved"); // RULE_16

  c_entry: cover property (state_ff.ctl.pc_load);
  c_return: cover property (state_ff.ctl.ctx_restore);
  c_wake: cover property (state_ff.ctl.wake);
  c_ext: cover property (ext_edge && state_ff.int_control[irq_pkg::BIT_EXT_EN]);
endmodule // core_interrupt_controller

`default_nettype wire

/* File: logic/irq_pkg.sv */
/*
  Shared constants and types of the core interrupt controller: register
  offsets, bit positions, reset values, sequencer states, context and
  core-control bundles. Assumes a 32-bit APB with byte addresses.
*/
package irq_pkg;
  // clock and instruction cycle
  localparam int CLK_PERIOD_NS = 50;
  localparam int TCY_NS = 200;
  localparam int Q_PER_TCY = TCY_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] ADDR_INT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PERIPH_EN_ONE = 8'h04;
  localparam logic [7:0] ADDR_PERIPH_EN_TWO = 8'h08;
  localparam logic [7:0] ADDR_PERIPH_FLAG_ONE = 8'h0C;
  localparam logic [7:0] ADDR_PERIPH_FLAG_TWO = 8'h10;
  localparam logic [7:0] ADDR_OPTION = 8'h14;
  localparam logic [7:0] ADDR_SHADOW_LO = 8'h18;
  localparam logic [7:0] ADDR_SHADOW_HI = 8'h1C;
  localparam logic [7:0] ADDR_SEQ_STATUS = 8'h20;

  // interrupt_control fields, bit 7 down to bit 0
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_EN = 6;
  localparam int BIT_T0_EN = 5;
  localparam int BIT_EXT_EN = 4;
  localparam int BIT_CHG_EN = 3;
  localparam int BIT_T0_FLAG = 2;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_CHG_FLAG = 0;
  // option register: edge select of the external pin
  localparam int BIT_EDGE_SEL = 6;

  // reset values
  localparam logic [7:0] INT_CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIPH_EN_RST = 8'h00;
  localparam logic [7:0] PERIPH_FLAG_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'h00;

  // implemented bits of the second peripheral registers (bit 4 absent)
  localparam logic [7:0] PERIPH_TWO_MASK = 8'hEF;
  // timeout and power-down bits of status are not saved
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h18;

  localparam int PC_W = 15;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;

  typedef struct packed {
    logic [15:0] file_select_one;
    logic [15:0] file_select_zero;
    logic [7:0] pc_high_latch;
    logic [7:0] bank_select_register;
    logic [7:0] status;
    logic [7:0] work;
  } ctx_t;

  typedef struct packed {
    logic flush;
    logic stack_push;
    logic pc_load;
    logic stack_pop;
    logic ctx_restore;
    logic wake;
  } ctl_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FLUSH = 3'b001,
    S_PUSH = 3'b010,
    S_WAKE = 3'b011
  } seq_t;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } qphase_t;
endpackage

/* File: logic/qphase_gen.sv */
/*
  Quarter-phase divider: splits the core clock into four quarter-phases
  and gives a one-cycle enable during the first quarter of each
  instruction cycle. Assumes one quarter-phase per core clock.
*/
`timescale 1ns/10ps
`default_nettype none

module qphase_gen (
  input wire logic clk,
  input wire logic rstn,
  output logic q1_en
);
  typedef struct packed {
    irq_pkg::qphase_t ph;
    logic q1;
  } qstate_t;

  qstate_t state_ff;
  qstate_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff.ph)
      irq_pkg::Q1: nxt_state.ph = irq_pkg::Q2;
      irq_pkg::Q2: nxt_state.ph = irq_pkg::Q3;
      irq_pkg::Q3: nxt_state.ph = irq_pkg::Q4;
      default: nxt_state.ph = irq_pkg::Q1;
    endcase
    nxt_state.q1 = (nxt_state.ph == irq_pkg::Q1);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff.ph <= irq_pkg::Q4;
      state_ff.q1 <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign q1_en = state_ff.q1;
endmodule // qphase_gen

`default_nettype wire

/* File: tb/core_interrupt_controller_tb_top.sv */
/*
  Self-checking bench of the core interrupt controller: APB traffic,
  events, external pin, sleep and return through the core stand-in.
  Assumes irq_pkg and a 50 ns core clock.
*/
`timescale 1ns/10ps
`default_nettype none

module core_interrupt_controller_tb_top;
  localparam int FL = 5;
  localparam int LD = 3;
  localparam int PP = 2;
  localparam int WK = 0;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  logic tmr = 1'b0;
  logic [7:0] ev1 = 8'h00;
  logic [7:0] ev2 = 8'h00;
  logic chg = 1'b0;
  logic pin = 1'b1;
  logic sleep_req = 1'b0;
  logic ret_req = 1'b0;
  logic asleep;
  logic ret_pulse;
  irq_pkg::ctx_t ctx_val = '0;
  irq_pkg::ctx_t ctx_live;
  irq_pkg::ctx_t ctx_out;
  irq_pkg::ctl_t ctl;
  logic [14:0] vec;
  int err_count = 0;
  int tests_run = 0;
  int seed = 32'h0A5B;
  int flushes = 0;

  core_interrupt_controller u_core_interrupt_controller (
    .CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TIMER_ZERO_OVF(tmr), .PERIPH_EVT_ONE(ev1), .PERIPH_EVT_TWO(ev2),
    .PIN_CHANGE_ANY(chg), .EXT_PIN(pin), .SLEEP_ACTIVE(asleep), .RETURN_INSTR(ret_pulse),
    .CTX_IN(ctx_live), .CORE_CTL(ctl), .CTX_OUT(ctx_out), .PC_VECTOR(vec));

  core_model u_core_model (
    .clk(clk), .rstn(rstn), .ctl(ctl), .ctx_val(ctx_val), .sleep_req(sleep_req),
    .ret_req(ret_req), .ctx_live(ctx_live), .asleep(asleep), .ret_pulse(ret_pulse),
    .depth());

  initial forever #25 clk = ~clk;

  always @(posedge clk) flushes <= flushes + int'(ctl.flush);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    chk(n < 8, 1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  // n = 99 when the pulse did not come within lim cycles
  task automatic wait_ctl(input int k, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ctl[k] !== 1'b1 && n < lim);
    if (ctl[k] !== 1'b1) n = 99;
  endtask

  task automatic kick;
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
  endtask

  task automatic do_return;
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
  endtask

  task automatic nap;
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic leave(input logic [7:0] fa, input logic [31:0] fv, input logic again);
    int f0;
    wr(fa, fv);
    do_return;
    f0 = flushes;
    repeat (16) @(posedge clk);
    chk(flushes != f0, again);
  endtask

  task automatic do_reset;
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #(50 * 40000);
    err_count++;
    stop_test;
  end

  initial begin
    logic [31:0] r;
    logic [31:0] v;
    int n;
    int f0;
    int b;
    do_reset;
    for (int a = 0; a <= 32; a += 4) rd(a[7:0], 32'h0);
    apb(1'b0, 8'h24, 32'h0, r);
    chk(r, 32'h0);
    chk(last_err, 1'b1);
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'hFF);
    wr(8'h08, 32'hFF);
    rd(8'h08, 32'hEF);
    wr(8'h00, 32'h78);
    rd(8'h00, 32'h78);
    chg <= 1'b1;
    rd(8'h00, 32'h79);
    chg <= 1'b0;
    wr(8'h00, 32'h79);
    rd(8'h00, 32'h78);
    do_reset;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    for (int s = 0; s < 2; s++) begin
      wr(8'h14, s << 6);
      for (int l = 0; l < 2; l++) begin
        pin <= l[0];
        repeat (6) @(posedge clk);
        rd(8'h00, {30'h0, l == s, 1'b0});
        wr(8'h00, 32'h0);
      end
    end
    wr(8'h00, 32'h90);
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    pin <= 1'b1;
    wait_ctl(LD, 30, n);
    chk(n < 30, 1);
    leave(8'h00, 32'h10, 1'b0);
    for (int i = 0; i < 4; i++) begin
      ctx_val <= {$random(seed), $random(seed)};
      wr(8'h00, 32'hA0);
      repeat (i) @(posedge clk);
      kick;
      wait_ctl(LD, 20, n);
      chk(n >= 10 && n <= 13, 1);
      chk(vec, 15'h0004);
      rd(8'h00, 32'h24);
      rd(8'h18, ctx_val[31:0] & 32'hFFFFE7FF);
      rd(8'h1C, ctx_val[63:32]);
      v = $random(seed);
      wr(8'h18, v);
      wr(8'h00, 32'h20);
      do_return;
      wait_ctl(PP, 4, n);
      chk(n, 2);
      chk(ctl[1], 1'b1);
      chk(ctx_out[31:0], (v & 32'hFFFFE7FF) | (ctx_val[31:0] & 32'h0000_1800));
      chk(ctx_out[63:32], ctx_val[63:32]);
      rd(8'h00, 32'hA0);
    end
    kick;
    wait_ctl(LD, 20, n);
    chk(n >= 10 && n <= 13, 1);
    leave(8'h00, 32'h24, 1'b1);
    leave(8'h00, 32'h20, 1'b0);
    for (int j = 0; j < 2; j++) begin
      b = $unsigned($random(seed)) % 8;
      if (j == 1 && b == 4) b = 5;
      wr(8'h04 + 8'(4 * j), 32'h1 << b);
      wr(8'h00, 32'h80);
      ev1 <= (j == 0) ? 8'h01 << b : 8'h00;
      ev2 <= (j == 1) ? 8'h01 << b : 8'h00;
      @(posedge clk);
      ev1 <= 8'h00;
      ev2 <= 8'h00;
      f0 = flushes;
      repeat (12) @(posedge clk);
      chk(flushes - f0, 0);
      rd(8'h0C + 8'(4 * j), 32'h1 << b);
      wr(8'h00, 32'hC0);
      wait_ctl(LD, 20, n);
      chk(n < 20, 1);
      leave(8'h0C + 8'(4 * j), 32'h0, 1'b0);
    end
    wr(8'h00, 32'h20);
    nap;
    kick;
    wait_ctl(WK, 4, n);
    chk(n < 4, 1);
    f0 = flushes;
    repeat (16) @(posedge clk);
    chk(flushes - f0, 0);
    wr(8'h00, 32'h20);
    wr(8'h00, 32'hA0);
    nap;
    kick;
    wait_ctl(WK, 4, n);
    chk(n, 2);
    wait_ctl(FL, 4, n);
    chk(n, 99);
    wait_ctl(LD, 20, n);
    chk(n < 20, 1);
    leave(8'h00, 32'h20, 1'b0);
    stop_test;
  end
endmodule // core_interrupt_controller_tb_top

`default_nettype wire

/* File: tb/core_model.sv */
/*
  Core stand-in: live context, sleep state, hardware stack depth and the
  return-from-interrupt pulse. Assumes one-cycle CORE_CTL pulses.
*/
`timescale 1ns/10ps
`default_nettype none

module core_model (
  input wire logic clk,
  input wire logic rstn,
  input wire irq_pkg::ctl_t ctl,
  input wire irq_pkg::ctx_t ctx_val,
  input wire logic sleep_req,
  input wire logic ret_req,
  output var irq_pkg::ctx_t ctx_live,
  output logic asleep,
  output logic ret_pulse,
  output logic [3:0] depth
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctx_live <= '0;
      asleep <= 1'b0;
      ret_pulse <= 1'b0;
      depth <= 4'h0;
    end else begin
      ctx_live <= ctx_val;
      // asleep until the wake pulse
      asleep <= sleep_req | (asleep & !ctl.wake);
      // return only from inside a handler
      ret_pulse <= ret_req & (depth != 4'h0);
      depth <= depth + {3'h0, ctl.stack_push} - {3'h0, ctl.stack_pop};
    end
  end
endmodule // core_model

`default_nettype wire
